// file: hdl/dpc_counter.sv
// dual 16-bit programmable counter with avalon-mm register slave
// assumes a single 250 MHz clock; both pins are asynchronous inputs

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - mode from mode-select and frequency bits
// - two-bit field picks the counting clock
// - invert bit inverts the measured input
// - overflow-source zero: timing counter overflow interrupts
// - counter irq needs its enable and global
// - reload value loads timing counter, reloaded on overflow
// - run bit starts; clearing it stops counting
// - pulse falling edge stops, clears run, interrupts
// - pulse overflow while high interrupts, keeps counting
// - stopped pulse count held for software read
// - frequency overflow interrupts and clears run
// - frequency result left in reload counter
module dpc_counter
    import dpc_pkg::*;
#(
    parameter int INSTR_DIV = INSTR_CLK_DIV
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  avm_address,
    input  wire logic        avm_read,
    input  wire logic        avm_write,
    input  wire logic [31:0] avm_writedata,
    input  wire logic [3:0]  avm_byteenable,
    output logic      [31:0] avm_readdata,
    output logic             avm_waitrequest,
    input  wire logic        measured_input_pin,
    input  wire logic        external_crystal_clock,
    output logic             irq,
    output logic             counter_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic reg_sel(input logic [7:0] addr, input logic [5:0] idx);
        return (addr[1:0] == 2'b00) && (addr[7:2] == idx);
    endfunction

    function automatic dpc_mode_t mode_of(input logic mode_bit, input logic freq_bit);
        dpc_mode_t m;
        m = MODE_NONE;
        unique case ({mode_bit, freq_bit})
            2'b00: m = MODE_COUNT;
            2'b10: m = MODE_PULSE;
            2'b01: m = MODE_FREQ;
            2'b11: m = MODE_NONE;
        endcase
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [7:0]       ctl_reg;
    logic [15:0]      timing_reg;
    logic [15:0]      reload_reg;
    logic             gie_reg;
    logic             ct_flag_reg;
    logic             ct_en_reg;
    logic [EVT_W-1:0] evt_status_reg;
    logic [EVT_W-1:0] evt_enable_reg;
    logic             wait_reg;
    logic [31:0]      rdata_reg;
    logic             irq_reg;
    logic             ct_irq_reg;

    logic             int_tick;
    logic             instr_tick;
    logic             meas_level;
    logic             meas_rise;
    logic             meas_fall;
    logic             eck_rise;

    ////////////////////////////////////////////////////////////////////////////
    // clock enables and pin conditioning

    dpc_rate_div #(
        .DIV (INT_CLK_DIV)
    ) u_int_div (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tick    (int_tick)
    );

    dpc_rate_div #(
        .DIV (INSTR_DIV)
    ) u_instr_div (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tick    (instr_tick)
    );

    dpc_pin_sync u_meas_sync (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .pin_async (measured_input_pin),
        .invert    (ctl_reg[CTL_INV_BIT]),
        .level     (meas_level),
        .rise      (meas_rise),
        .fall      (meas_fall)
    );

    dpc_pin_sync u_eck_sync (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .pin_async (external_crystal_clock),
        .invert    (1'b0),
        .level     (),
        .rise      (eck_rise),
        .fall      ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic       wr_acc;
    logic [7:0] wbyte;
    logic       wr_ctl;
    logic       wr_rel_hi;
    logic       wr_rel_lo;
    logic       wr_gie;
    logic       wr_flags2;
    logic       wr_ens2;
    logic       wr_evt_clr;
    logic       wr_evt_en;

    // a write lands only at the edge where waitrequest is seen low
    assign wr_acc     = avm_write & ~wait_reg & avm_byteenable[0];
    assign wbyte      = avm_writedata[7:0];
    assign wr_ctl     = wr_acc & reg_sel(avm_address, IDX_CONTROL);
    assign wr_rel_hi  = wr_acc & reg_sel(avm_address, IDX_RELOAD_HI);
    assign wr_rel_lo  = wr_acc & reg_sel(avm_address, IDX_RELOAD_LO);
    assign wr_gie     = wr_acc & reg_sel(avm_address, IDX_GLOBAL_EN);
    assign wr_flags2  = wr_acc & reg_sel(avm_address, IDX_IRQ_FLAGS2);
    assign wr_ens2    = wr_acc & reg_sel(avm_address, IDX_IRQ_ENS2);
    assign wr_evt_clr = wr_acc & reg_sel(avm_address, IDX_EVT_CLEAR);
    assign wr_evt_en  = wr_acc & reg_sel(avm_address, IDX_EVT_ENABLE);

    ////////////////////////////////////////////////////////////////////////////
    // mode, clock selection and counting conditions

    dpc_mode_t mode;
    dpc_src_t  src;
    logic      run;
    logic      count_tick;
    logic      a_adv;
    logic      a_ovf;
    logic      b_adv;
    logic      b_ovf;
    logic      pulse_end;
    logic      freq_end;
    logic      freq_start;
    logic      ct_event;
    logic [15:0] reload_next;

    assign mode = mode_of(ctl_reg[CTL_MODE_BIT], ctl_reg[CTL_FREQ_BIT]);
    assign src  = dpc_src_t'(ctl_reg[CTL_SRC_HI:CTL_SRC_LO]);
    assign run  = ctl_reg[CTL_RUN_BIT];

    always_comb
    begin
        count_tick = 1'b0;
        unique case (src)
            SRC_MEASURED: count_tick = meas_rise;
            SRC_EXTERNAL: count_tick = eck_rise;
            SRC_INSTR:    count_tick = instr_tick;
            SRC_INTERNAL: count_tick = int_tick;
        endcase
    end

    // the invalid mode never counts
    always_comb
    begin
        a_adv = 1'b0;
        unique case (mode)
            MODE_COUNT: a_adv = run & count_tick;
            MODE_PULSE: a_adv = run & count_tick & meas_level;
            MODE_FREQ:  a_adv = run & count_tick;
            MODE_NONE:  a_adv = 1'b0;
        endcase
    end

    assign a_ovf     = a_adv & (timing_reg == COUNT_MAX);
    assign pulse_end = run & (mode == MODE_PULSE) & meas_fall;
    assign freq_end  = (mode == MODE_FREQ) & a_ovf;
    assign b_adv     = run & (mode == MODE_FREQ) & meas_rise;
    assign b_ovf     = b_adv & (reload_reg == COUNT_MAX);

    // a fresh start of a frequency run clears the edge count
    assign freq_start = wr_ctl & ~run & wbyte[CTL_RUN_BIT] & wbyte[CTL_FREQ_BIT]
                      & ~wbyte[CTL_MODE_BIT];

    // overflow source picks which counter raises the counter interrupt
    assign ct_event = pulse_end | (ctl_reg[CTL_OVSRC_BIT] ? b_ovf : a_ovf);

    assign reload_next = {wr_rel_hi ? wbyte : reload_reg[15:8],
                          wr_rel_lo ? wbyte : reload_reg[7:0]};

    ////////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ctl_reg <= CTL_RESET;
        else if (pulse_end || freq_end)
            ctl_reg <= (wr_ctl ? {wbyte[7:1], 1'b0} : ctl_reg)
                       & ~(8'h01 << CTL_RUN_BIT);
        else if (wr_ctl)
            ctl_reg <= {wbyte[7:1], 1'b0};
    end

    ////////////////////////////////////////////////////////////////////////////
    // timing counter

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            timing_reg <= COUNT_RESET;
        else if (wr_rel_hi || wr_rel_lo)
            timing_reg <= reload_next;
        else if (pulse_end)
            timing_reg <= timing_reg;
        else if (a_ovf)
            timing_reg <= reload_reg;
        else if (a_adv)
            timing_reg <= timing_reg + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // reload counter

    // in frequency mode it holds the edge count once the gate closes
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            reload_reg <= COUNT_RESET;
        else if (wr_rel_hi || wr_rel_lo)
            reload_reg <= reload_next;
        else if (freq_start)
            reload_reg <= COUNT_RESET;
        else if (b_adv)
            reload_reg <= reload_reg + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter interrupt flag and enables

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            gie_reg   <= 1'b0;
            ct_en_reg <= 1'b0;
        end
        else
        begin
            if (wr_gie)
                gie_reg <= wbyte[GIE_BIT];
            if (wr_ens2)
                ct_en_reg <= wbyte[CT_IRQ_BIT];
        end
    end

    // a hardware set in the same cycle as a software clear wins
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ct_flag_reg <= 1'b0;
        else if (ct_event)
            ct_flag_reg <= 1'b1;
        else if (wr_flags2)
            ct_flag_reg <= wbyte[CT_IRQ_BIT];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ct_irq_reg <= 1'b0;
        else
            ct_irq_reg <= ct_flag_reg & ct_en_reg & gie_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky event status, clear and enable

    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_next;

    always_comb
    begin
        evt_set                = '0;
        evt_set[EVT_COUNTER]   = ct_event;
        evt_set[EVT_PULSE_END] = pulse_end;
        evt_set[EVT_FREQ_END]  = freq_end;
        evt_set[EVT_RELOAD_OV] = b_ovf;
        evt_next = (evt_status_reg & ~(wr_evt_clr ? wbyte[EVT_W-1:0] : EVT_RESET))
                 | evt_set;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            evt_status_reg <= EVT_RESET;
        else
            evt_status_reg <= evt_next;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            evt_enable_reg <= EVT_RESET;
        else if (wr_evt_en)
            evt_enable_reg <= wbyte[EVT_W-1:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(evt_next & evt_enable_reg);
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake and read data

    logic [7:0] rbyte;

    always_comb
    begin
        rbyte = BYTE_RESET;
        if (avm_address[1:0] == 2'b00)
        begin
            unique case (avm_address[7:2])
                IDX_GLOBAL_EN:  rbyte = {gie_reg, 7'h00};
                IDX_TIMING_HI:  rbyte = timing_reg[15:8];
                IDX_TIMING_LO:  rbyte = timing_reg[7:0];
                IDX_RELOAD_HI:  rbyte = reload_reg[15:8];
                IDX_RELOAD_LO:  rbyte = reload_reg[7:0];
                IDX_CONTROL:    rbyte = ctl_reg;
                IDX_IRQ_FLAGS2: rbyte = {5'h00, ct_flag_reg, 2'h0};
                IDX_IRQ_ENS2:   rbyte = {5'h00, ct_en_reg, 2'h0};
                IDX_EVT_STATUS: rbyte = {4'h0, evt_status_reg};
                IDX_EVT_ENABLE: rbyte = {4'h0, evt_enable_reg};
                default:        rbyte = BYTE_RESET;
            endcase
        end
    end

    // fixed one-cycle wait: every access completes on its second edge
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            wait_reg <= 1'b1;
        else if (wait_reg && (avm_read || avm_write))
            wait_reg <= 1'b0;
        else
            wait_reg <= 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rdata_reg <= 32'h00000000;
        else if (wait_reg && avm_read)
            rdata_reg <= {24'h000000, rbyte};
    end

    assign avm_waitrequest = wait_reg;
    assign avm_readdata    = rdata_reg;
    assign irq             = irq_reg;
    assign counter_irq     = ct_irq_reg;

endmodule

// file: pkg/dpc_pkg.sv
// constants and types shared by the dual programmable counter design
// assumes a 250 MHz system clock and a 32-bit avalon-mm register bus
package dpc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock rates and dividers
    localparam int SYS_CLK_HZ    = 250_000_000;
    localparam int INT_CLK_HZ    = 1_000_000;
    localparam int INT_CLK_DIV   = SYS_CLK_HZ / INT_CLK_HZ;
    localparam int INSTR_CLK_DIV = 8;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_GLOBAL_EN  = 6'h07;
    localparam logic [5:0] IDX_TIMING_HI  = 6'h08;
    localparam logic [5:0] IDX_TIMING_LO  = 6'h09;
    localparam logic [5:0] IDX_RELOAD_HI  = 6'h0A;
    localparam logic [5:0] IDX_RELOAD_LO  = 6'h0B;
    localparam logic [5:0] IDX_CONTROL    = 6'h0C;
    localparam logic [5:0] IDX_IRQ_FLAGS2 = 6'h16;
    localparam logic [5:0] IDX_IRQ_ENS2   = 6'h17;
    localparam logic [5:0] IDX_EVT_STATUS = 6'h18;
    localparam logic [5:0] IDX_EVT_CLEAR  = 6'h19;
    localparam logic [5:0] IDX_EVT_ENABLE = 6'h1A;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTL_RUN_BIT   = 7;
    localparam int CTL_MODE_BIT  = 6;
    localparam int CTL_SRC_HI    = 5;
    localparam int CTL_SRC_LO    = 4;
    localparam int CTL_INV_BIT   = 3;
    localparam int CTL_FREQ_BIT  = 2;
    localparam int CTL_OVSRC_BIT = 1;
    localparam int GIE_BIT       = 7;
    localparam int CT_IRQ_BIT    = 2;

    // sticky event bits
    localparam int EVT_COUNTER   = 0;
    localparam int EVT_PULSE_END = 1;
    localparam int EVT_FREQ_END  = 2;
    localparam int EVT_RELOAD_OV = 3;
    localparam int EVT_W         = 4;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset and the counter maximum
    localparam logic [7:0]  CTL_RESET   = 8'h00;
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
    localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

    typedef enum logic [1:0] {
        SRC_INTERNAL,
        SRC_INSTR,
        SRC_EXTERNAL,
        SRC_MEASURED
    } dpc_src_t;

    typedef enum logic [1:0] {
        MODE_COUNT,
        MODE_PULSE,
        MODE_FREQ,
        MODE_NONE
    } dpc_mode_t;

endpackage

// file: hdl/dpc_pin_sync.sv
// two-flop synchroniser for a pin, with optional inversion and edge pulses
// assumes the pin is asynchronous to sys_clk
module dpc_pin_sync
    import dpc_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic pin_async,
    input  wire logic invert,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic meta_reg;
    logic sync_reg;
    logic level_reg;
    logic prev_reg;

    // changing invert toggles level and gives one false edge
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            meta_reg  <= 1'b0;
            sync_reg  <= 1'b0;
            level_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end
        else
        begin
            meta_reg  <= pin_async;
            sync_reg  <= meta_reg;
            level_reg <= sync_reg ^ invert;
            prev_reg  <= level_reg;
        end
    end

    assign level = level_reg;
    assign rise  = level_reg & ~prev_reg;
    assign fall  = ~level_reg & prev_reg;

endmodule

// file: hdl/dpc_rate_div.sv
// divider giving a one-cycle enable pulse every DIV system clocks
// assumes DIV is at least 2
module dpc_rate_div
    import dpc_pkg::*;
#(
    parameter int DIV = INT_CLK_DIV
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    output logic      tick
);

    localparam int CW = $clog2(DIV);

    logic [CW-1:0] count_reg;
    logic          tick_reg;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            count_reg <= '0;
            tick_reg  <= 1'b0;
        end
        else if (count_reg == CW'(DIV - 1))
        begin
            count_reg <= '0;
            tick_reg  <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + 1'b1;
            tick_reg  <= 1'b0;
        end
    end

    assign tick = tick_reg;

endmodule

// file: testbench/dpc_pin_model.sv
// pin model: free-running crystal and a measured signal for dpc_counter
// assumes the bench picks an oscillating or a steered measured level
module dpc_pin_model
#(
    parameter real XTAL_HALF_NS = 162.7,
    parameter real MEAS_HALF_NS = 40.9
)
(
    input  wire logic osc_en,
    input  wire logic level_in,
    output logic      measured_input_pin,
    output logic      external_crystal_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic osc = 1'b0;
    // odd half periods keep all but every 20th edge of each pin off the system clock edges
    initial external_crystal_clock = 1'b0;
    always #(XTAL_HALF_NS) external_crystal_clock = ~external_crystal_clock;
    always #(MEAS_HALF_NS) osc = ~osc;
    assign measured_input_pin = osc_en ? osc : level_in;
endmodule

// file: testbench/dpc_counter_checker.sv
// assertions on the bus and interrupt ports of dpc_counter
// assumes a bind to dpc_counter; enables are shadowed from bus writes
module dpc_counter_checker
    import dpc_pkg::*;
#(
    parameter int INSTR_DIV = INSTR_CLK_DIV
)
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  avm_address,
    input wire logic        avm_read,
    input wire logic        avm_write,
    input wire logic [31:0] avm_writedata,
    input wire logic [3:0]  avm_byteenable,
    input wire logic [31:0] avm_readdata,
    input wire logic        avm_waitrequest,
    input wire logic        irq,
    input wire logic        counter_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic             wr_done;
    logic             rd_done;
    logic             gie_reg;
    logic             counter_irq_enable_reg;
    logic [EVT_W-1:0] evt_en_reg;
    assign wr_done = avm_write && !avm_waitrequest && avm_byteenable[0];
    assign rd_done = avm_read && !avm_waitrequest;
    ////////////////////////////////////////////////////////////////
    // shadows update on the same edge as the real enables
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            gie_reg    <= 1'b0;
            counter_irq_enable_reg   <= 1'b0;
            evt_en_reg <= EVT_RESET;
        end
        else if (wr_done)
        begin
            if (avm_address == {IDX_GLOBAL_EN, 2'b00})
                gie_reg <= avm_writedata[GIE_BIT];
            if (avm_address == {IDX_IRQ_ENS2, 2'b00})
                counter_irq_enable_reg <= avm_writedata[CT_IRQ_BIT];
            if (avm_address == {IDX_EVT_ENABLE, 2'b00})
                evt_en_reg <= avm_writedata[EVT_W-1:0];
        end
    end
    ////////////////////////////////////////////////////////////////
    a_wait_answer: assert property ((avm_read || avm_write) && avm_waitrequest
        |=> !avm_waitrequest) else $error("request not answered in one cycle");
    a_wait_single: assert property (!avm_waitrequest |=> avm_waitrequest)
        else $error("waitrequest low too long");
    a_read_high_zero: assert property (rd_done |-> avm_readdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (rd_done && avm_address[7:2] > IDX_EVT_ENABLE
        |-> avm_readdata == 32'h00000000) else $error("unmapped read not zero");
    a_irq_gated: assert property (counter_irq |-> $past(gie_reg && counter_irq_enable_reg))
        else $error("counter irq without both enables");
    a_gie_off: assert property (wr_done && avm_address == {IDX_GLOBAL_EN, 2'b00}
        && !avm_writedata[GIE_BIT] |-> ##2 !counter_irq) else $error("irq after disable");
    a_flag_sets: assert property (wr_done && avm_address == {IDX_IRQ_FLAGS2, 2'b00}
        && avm_writedata[CT_IRQ_BIT] && gie_reg && counter_irq_enable_reg |-> ##2 counter_irq)
        else $error("flag set gave no irq");
    a_irq_enabled: assert property (irq |-> evt_en_reg != 0 || $past(evt_en_reg != 0))
        else $error("irq with no event enabled");
    c_counter_irq: cover property ($rose(counter_irq));
    c_irq: cover property ($rose(irq));
    c_gie_write: cover property (wr_done && avm_address == {IDX_GLOBAL_EN, 2'b00});
endmodule

// file: testbench/tb_top.sv
// self-checking bench for dpc_counter
// assumes dpc_pin_model drives the pins; random values use a fixed seed
module tb_top
    import dpc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  avm_address = 8'h00;
    logic        avm_read = 1'b0;
    logic        avm_write = 1'b0;
    logic [31:0] avm_writedata = 32'h00000000;
    logic [3:0]  avm_byteenable = 4'hF;
    logic [31:0] avm_readdata;
    logic        avm_waitrequest;
    logic        measured_input_pin;
    logic        external_crystal_clock;
    logic        irq;
    logic        counter_irq;
    logic        osc_en = 1'b0;
    logic        level = 1'b0;
    logic [7:0]  rd;
    logic [7:0]  v;
    logic [7:0]  r;
    int          mismatches = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          seed = 32'h2874;
    int          t0, w;
    int          tmin [4] = '{480, 2, 140, 35};
    int          tmax [4] = '{1000, 24, 300, 90};
    logic [5:0]  ridx [7] = '{IDX_GLOBAL_EN, IDX_TIMING_HI, IDX_CONTROL, IDX_IRQ_FLAGS2,
                              IDX_IRQ_ENS2, IDX_EVT_STATUS, 6'h30};
    always #2 sys_clk = ~sys_clk;
    dpc_counter #(.INSTR_DIV(2)) u_dpc_counter (.sys_clk(sys_clk), .rst(rst),
        .avm_address(avm_address), .avm_read(avm_read), .avm_write(avm_write),
        .avm_writedata(avm_writedata), .avm_byteenable(avm_byteenable),
        .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
        .measured_input_pin(measured_input_pin),
        .external_crystal_clock(external_crystal_clock), .irq(irq), .counter_irq(counter_irq));
    dpc_pin_model u_dpc_pin_model (.osc_en(osc_en), .level_in(level),
        .measured_input_pin(measured_input_pin), .external_crystal_clock(external_crystal_clock));
    ////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            finish_test();
        end
    end
    // one access; an idle edge follows so strobes never toggle twice at once
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        avm_address <= {idx, 2'b00};
        avm_writedata <= {24'h000000, d};
        avm_write <= wr;
        avm_read <= ~wr;
        @(posedge sys_clk);
        while (avm_waitrequest !== 1'b0)
            @(posedge sys_clk);
        rd = avm_readdata[7:0];
        avm_write <= 1'b0;
        avm_read <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
        num_checks++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            mismatches++;
            $display("ERROR %0t: %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic clear_all();
        bus(1, IDX_EVT_CLEAR, 8'h0F);
        bus(1, IDX_IRQ_FLAGS2, 8'h00);
        repeat (3) @(posedge sys_clk);
        chk({6'h00, irq, counter_irq}, 8'h00);
    endtask
    // polls the run bit; hardware clears it when a measurement ends
    task automatic wait_stop();
        rd = 8'h80;
        for (int n = 0; n < 400 && rd[7] !== 1'b0; n++)
            bus(0, IDX_CONTROL, 8'h00);
    endtask
    task automatic run_count(input logic [1:0] s, input logic [7:0] lo, input int t1,
                             input int t2);
        bus(1, IDX_RELOAD_HI, 8'hFF);
        bus(1, IDX_RELOAD_LO, lo);
        bus(0, IDX_TIMING_LO, 8'h00);
        chk(rd, lo);
        bus(1, IDX_CONTROL, {2'b10, s, 4'h0});
        t0 = cycles;
        for (int n = 0; n < 2000 && counter_irq !== 1'b1; n++)
            @(posedge sys_clk);
        chk_rng(16'(cycles - t0), t1, t2);
        chk({6'h00, irq, counter_irq}, 8'h03);
        bus(0, IDX_TIMING_HI, 8'h00);
        chk(rd, 8'hFF);
        bus(1, IDX_CONTROL, 8'h00);
        bus(0, IDX_TIMING_LO, 8'h00);
        v = rd;
        repeat (20) @(posedge sys_clk);
        bus(0, IDX_TIMING_LO, 8'h00);
        chk(rd, v);
        bus(0, IDX_EVT_STATUS, 8'h00);
        chk(rd, 8'h01);
        bus(0, IDX_IRQ_FLAGS2, 8'h00);
        chk(rd, 8'h04);
        clear_all();
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        foreach (ridx[i])
        begin
            bus(0, ridx[i], 8'h00);
            chk(rd, 8'h00);
        end
        bus(1, IDX_TIMING_HI, 8'h55);
        bus(0, IDX_TIMING_HI, 8'h00);
        chk(rd, 8'h00);
        bus(1, IDX_IRQ_ENS2, 8'h04);
        bus(1, IDX_GLOBAL_EN, 8'h80);
        bus(1, IDX_EVT_ENABLE, 8'h0F);
        avm_byteenable <= 4'hE;
        bus(1, IDX_IRQ_ENS2, 8'h00);
        avm_byteenable <= 4'hF;
        bus(0, IDX_IRQ_ENS2, 8'h00);
        chk(rd, 8'h04);
        osc_en <= 1'b1;
        for (int s = 0; s < 4; s++)
            run_count(2'(s), 8'hFD, tmin[s], tmax[s]);
        repeat (4)
        begin
            r = 8'hC0 | 8'($random(seed));
            run_count(2'b01, r, 2 * (256 - r) - 2, 2 * (256 - r) + 8);
        end
        bus(1, IDX_RELOAD_LO, 8'hF0);
        bus(1, IDX_CONTROL, 8'h92);
        repeat (100) @(posedge sys_clk);
        bus(0, IDX_EVT_STATUS, 8'h00);
        chk(rd, 8'h00);
        bus(1, IDX_CONTROL, 8'h00);
        bus(1, IDX_GLOBAL_EN, 8'h00);
        bus(1, IDX_IRQ_FLAGS2, 8'h04);
        repeat (3) @(posedge sys_clk);
        chk({7'h00, counter_irq}, 8'h00);
        bus(1, IDX_GLOBAL_EN, 8'h80);
        bus(1, IDX_IRQ_FLAGS2, 8'h04);
        repeat (3) @(posedge sys_clk);
        chk({7'h00, counter_irq}, 8'h01);
        clear_all();
        // second pass inverted, with an overflow inside the pulse
        osc_en <= 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            level <= k[0];
            w = (k == 0) ? 40 + ($random(seed) & 63) : 120;
            bus(1, IDX_RELOAD_HI, k ? 8'hFF : 8'h00);
            bus(1, IDX_RELOAD_LO, k ? 8'hE0 : 8'h00);
            bus(1, IDX_CONTROL, {4'h5, k[0], 3'h0});
            bus(1, IDX_CONTROL, {4'hD, k[0], 3'h0});
            level <= ~k[0];
            repeat (w) @(posedge sys_clk);
            level <= k[0];
            wait_stop();
            chk(rd, {4'h5, k[0], 3'h0});
            bus(0, IDX_TIMING_LO, 8'h00);
            chk_rng({8'h00, rd}, k ? 250 : w / 2 - 2, k ? 254 : w / 2 + 2);
            bus(0, IDX_TIMING_HI, 8'h00);
            chk(rd, k ? 8'hFF : 8'h00);
            bus(0, IDX_EVT_STATUS, 8'h00);
            chk(rd, 8'h03);
            clear_all();
        end
        osc_en <= 1'b1;
        bus(1, IDX_RELOAD_HI, 8'hFF);
        bus(1, IDX_RELOAD_LO, 8'h00);
        bus(1, IDX_CONTROL, 8'h14);
        bus(1, IDX_CONTROL, 8'h94);
        wait_stop();
        bus(0, IDX_RELOAD_LO, 8'h00);
        chk_rng({8'h00, rd}, 23, 27);
        bus(0, IDX_RELOAD_HI, 8'h00);
        chk(rd, 8'h00);
        bus(0, IDX_EVT_STATUS, 8'h00);
        chk(rd, 8'h05);
        bus(1, IDX_EVT_ENABLE, 8'h02);
        repeat (3) @(posedge sys_clk);
        chk({7'h00, irq}, 8'h00);
        bus(1, IDX_EVT_ENABLE, 8'h04);
        repeat (3) @(posedge sys_clk);
        chk({7'h00, irq}, 8'h01);
        clear_all();
        bus(1, IDX_RELOAD_LO, 8'h10);
        bus(1, IDX_CONTROL, 8'hD4);
        repeat (40) @(posedge sys_clk);
        bus(0, IDX_TIMING_LO, 8'h00);
        chk(rd, 8'h10);
        finish_test();
    end
endmodule
bind dpc_counter dpc_counter_checker #(.INSTR_DIV(INSTR_DIV)) u_dpc_counter_checker (
    .sys_clk(sys_clk), .rst(rst), .avm_address(avm_address), .avm_read(avm_read),
    .avm_write(avm_write), .avm_writedata(avm_writedata), .avm_byteenable(avm_byteenable),
    .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest), .irq(irq),
    .counter_irq(counter_irq));
